// ### verilog/psa_pkg.sv
// constants, register map and lfsr step for the pixel signature analyzer
package psa_pkg;
  localparam int PIX_W = 30;
  localparam int SIG_W = 33;
  localparam int REG_W = 10;
  localparam int ADDR_W = 11;
  localparam int CR_W = 8;
  // control register addresses on the host port
  localparam logic [10:0] ADDR_CMD_FOUR = 11'h008;
  localparam logic [10:0] ADDR_SIG_HIGH = 11'h010;
  localparam logic [10:0] ADDR_SIG_MID = 11'h011;
  localparam logic [10:0] ADDR_SIG_LOW = 11'h012;
  localparam logic [10:0] ADDR_SIG_EXTRA = 11'h013;
  // command register four field positions
  localparam int CLK_EN_POS = 5;
  localparam int RESET_POS = 6;
  localparam int FB_SEL_POS = 7;
  localparam logic [7:0] CMD_FOUR_RESET = 8'h00;
  // feedback taps: x^33 + x^20 + 1, maximal length
  localparam int TAP_HI = 32;
  localparam int TAP_LO = 19;
  // pipeline drain the host should allow before stopping the clock
  localparam int DRAIN_CYCLES = 20;
  localparam logic [32:0] SIG_RESET = 33'h0_0000_0000;
  localparam logic [9:0] REG_ZERO = 10'h000;

  function automatic logic [32:0] psa_lfsr_next(input logic [32:0] s,
                                                input logic [29:0] p);
    logic fb;
    fb = s[TAP_HI] ^ s[TAP_LO];
    psa_lfsr_next = {s[31:0], fb} ^ {3'h0, p};
  endfunction

  // one 10-bit view of the signature, picked by register address
  function automatic logic [9:0] psa_slice(input logic [32:0] s,
                                           input logic [10:0] a);
    if (a == ADDR_SIG_HIGH) begin
      psa_slice = s[30:21];
    end else if (a == ADDR_SIG_MID) begin
      psa_slice = s[20:11];
    end else if (a == ADDR_SIG_LOW) begin
      psa_slice = s[10:1];
    end else if (a == ADDR_SIG_EXTRA) begin
      psa_slice = {7'h00, s[32], s[31], s[0]};
    end else begin
      psa_slice = REG_ZERO;
    end
  endfunction
endpackage

// ### verilog/psa_lfsr.sv
// 33-bit signature shift register fed by the pixel word
`timescale 1ns/1ns
module psa_lfsr
  import psa_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic sig_clear,
  input wire logic clk_enable,
  input wire logic fb_select,
  input wire logic pixel_active,
  input wire logic [29:0] pixel_data,
  output logic [32:0] sig_value
);
  typedef struct packed {
    logic [32:0] sig;
  } psa_lfsr_state_t;

  psa_lfsr_state_t st_q;
  psa_lfsr_state_t st_d;

  always_comb begin
    st_d = st_q;
    if (sig_clear) begin
      st_d.sig = SIG_RESET;
    end else if (clk_enable && pixel_active) begin
      if (fb_select) begin
        st_d.sig = psa_lfsr_next(st_q.sig, pixel_data);
      end else begin
        st_d.sig = {3'h0, pixel_data};
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign sig_value = st_q.sig;

  a_hold_blank: assert property (@(posedge ref_clk)
    disable iff (reset)
    !pixel_active && !sig_clear |=> $stable(sig_value))
    else $error("signature moved during blanking");
  a_freeze_off: assert property (@(posedge ref_clk)
    disable iff (reset)
    !clk_enable && !sig_clear |=> $stable(sig_value))
    else $error("signature moved with clock disabled");
  a_clear_zero: assert property (@(posedge ref_clk)
    disable iff (reset)
    sig_clear |=> sig_value == SIG_RESET)
    else $error("signature not cleared");
  a_load_direct: assert property (@(posedge ref_clk)
    disable iff (reset)
    clk_enable && pixel_active && !fb_select && !sig_clear
    |=> sig_value == {3'h0, $past(pixel_data)})
    else $error("direct load mismatch");
  a_fb_shift: assert property (@(posedge ref_clk)
    disable iff (reset)
    clk_enable && pixel_active && fb_select && !sig_clear
    |=> sig_value == ({$past(sig_value[31:0]),
      $past(sig_value[TAP_HI] ^ sig_value[TAP_LO])}
      ^ {3'h0, $past(pixel_data)}))
    else $error("feedback shift mismatch");
endmodule

// ### verilog/psa_top.sv
// pixel signature analyzer with its host control port
`timescale 1ns/1ns
module psa_top
  import psa_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [29:0] pixel_data,
  input wire logic pixel_active,
  input wire logic mpu_c1,
  input wire logic mpu_c0,
  input wire logic mpu_rd,
  input wire logic mpu_wr,
  input wire logic mpu_bus10,
  input wire logic [9:0] mpu_d_in,
  output logic [9:0] mpu_d_out,
  output logic mpu_d_oe,
  output logic [32:0] signature
);
  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic [1:0] rd_s;
    logic [1:0] wr_s;
    logic [1:0] c1_s;
    logic [1:0] c0_s;
    logic [1:0] bus10_s;
    logic [9:0] din_s1;
    logic [9:0] din_s2;
    logic rd_prev;
    logic wr_prev;
    logic [10:0] addr;
    logic addr_hi;
    logic byte_hi;
    logic [7:0] cmd_four;
    logic clear;
    logic [9:0] dout;
  } psa_state_t;

  psa_state_t st_q;
  psa_state_t st_d;
  logic rd_rise;
  logic wr_rise;
  logic sel_ctrl;
  logic sel_addr;
  logic [9:0] rd_word;

  // host pins are asynchronous: stage [0] feeds only stage [1]
  assign rd_rise = st_q.rd_s[1] & ~st_q.rd_prev;
  assign wr_rise = st_q.wr_s[1] & ~st_q.wr_prev;
  assign sel_ctrl = st_q.c1_s[1] & ~st_q.c0_s[1];
  assign sel_addr = ~st_q.c1_s[1] & ~st_q.c0_s[1];

  always_comb begin
    if (st_q.addr == ADDR_CMD_FOUR) begin
      rd_word = {2'h0, st_q.cmd_four};
    end else begin
      rd_word = psa_slice(signature, st_q.addr);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    st_d = st_q;
    st_d.rd_s = {st_q.rd_s[0], mpu_rd};
    st_d.wr_s = {st_q.wr_s[0], mpu_wr};
    st_d.c1_s = {st_q.c1_s[0], mpu_c1};
    st_d.c0_s = {st_q.c0_s[0], mpu_c0};
    st_d.bus10_s = {st_q.bus10_s[0], mpu_bus10};
    st_d.din_s1 = mpu_d_in;
    st_d.din_s2 = st_q.din_s1;
    st_d.rd_prev = st_q.rd_s[1];
    st_d.wr_prev = st_q.wr_s[1];
    st_d.clear = 1'b0;
    if (wr_rise && sel_addr) begin
      // address goes in as low byte then high bits, like palette setup
      if (!st_q.addr_hi) begin
        st_d.addr[7:0] = st_q.din_s2[7:0];
        st_d.addr_hi = 1'b1;
      end else begin
        st_d.addr[10:8] = st_q.din_s2[2:0];
        st_d.addr_hi = 1'b0;
      end
      st_d.byte_hi = 1'b0;
    end else if (wr_rise && sel_ctrl) begin
      if (st_q.addr == ADDR_CMD_FOUR) begin
        st_d.cmd_four = st_q.din_s2[7:0];
        // restart only on the low-to-high return of the reset bit
        st_d.clear = ~st_q.cmd_four[RESET_POS]
                   & st_q.din_s2[RESET_POS];
      end
      // signature addresses take no write at all
      st_d.addr = st_q.addr + 11'h001;
    end else if (rd_rise && sel_addr) begin
      st_d.dout = {2'h0, st_q.addr[7:0]};
    end else if (rd_rise && sel_ctrl) begin
      if (st_q.bus10_s[1]) begin
        st_d.dout = rd_word;
        st_d.addr = st_q.addr + 11'h001;
      end else if (!st_q.byte_hi) begin
        st_d.dout = {2'h0, rd_word[9:2]};
        st_d.byte_hi = 1'b1;
      end else begin
        // second byte; a slice that changes in between splits the word
        st_d.dout = {8'h00, rd_word[1:0]};
        st_d.byte_hi = 1'b0;
        st_d.addr = st_q.addr + 11'h001;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  psa_lfsr u_lfsr (
    .ref_clk(ref_clk),
    .reset(reset),
    .sig_clear(st_q.clear),
    .clk_enable(st_q.cmd_four[CLK_EN_POS]),
    .fb_select(st_q.cmd_four[FB_SEL_POS]),
    .pixel_active(pixel_active),
    .pixel_data(pixel_data),
    .sig_value(signature)
  );

  assign mpu_d_out = st_q.dout;
  assign mpu_d_oe = st_q.rd_s[1];

  ////////////////////////////////////////////////////////////////////////////
  a_sig_readonly: assert property (@(posedge ref_clk)
    disable iff (reset)
    wr_rise && sel_ctrl && st_q.addr >= ADDR_SIG_HIGH
      && st_q.addr <= ADDR_SIG_EXTRA |=> $stable(st_q.cmd_four))
    else $error("signature write changed control state");
  a_reset_edge: assert property (@(posedge ref_clk)
    disable iff (reset)
    st_q.clear |-> st_q.cmd_four[RESET_POS]
      && !$past(st_q.cmd_four[RESET_POS]))
    else $error("clear without low-to-high reset bit");
  a_read_word: assert property (@(posedge ref_clk)
    disable iff (reset)
    rd_rise && sel_ctrl && st_q.bus10_s[1] && st_q.addr == ADDR_SIG_MID
    |=> mpu_d_out == $past(signature[20:11]))
    else $error("middle slice read mismatch");
  a_byte_pair: assert property (@(posedge ref_clk)
    disable iff (reset)
    rd_rise && sel_ctrl && !st_q.bus10_s[1] && !st_q.byte_hi
    |=> st_q.byte_hi && mpu_d_out[9:8] == 2'h0
      && $stable(st_q.addr))
    else $error("8-bit first byte sequencing wrong");

  ////////////////////////////////////////////////////////////////////////////
  // address register: low byte first, then the top three bits
  a_addr_low: assert property (@(posedge ref_clk)
    disable iff (reset)
    wr_rise && sel_addr && !st_q.addr_hi
    |=> st_q.addr_hi && st_q.addr[7:0] == $past(st_q.din_s2[7:0]))
    else $error("address low byte not taken");
  a_addr_high: assert property (@(posedge ref_clk)
    disable iff (reset)
    wr_rise && sel_addr && st_q.addr_hi
    |=> !st_q.addr_hi && st_q.addr[10:8] == $past(st_q.din_s2[2:0]))
    else $error("address high bits not taken");
  a_addr_byte: assert property (@(posedge ref_clk)
    disable iff (reset)
    wr_rise && sel_addr |=> !st_q.byte_hi)
    else $error("address write kept byte phase");
  a_addr_read: assert property (@(posedge ref_clk)
    disable iff (reset)
    rd_rise && sel_addr |=> mpu_d_out == {2'h0, $past(st_q.addr[7:0])})
    else $error("address read mismatch");
  // control writes: only command register four holds state
  a_cmd_take: assert property (@(posedge ref_clk)
    disable iff (reset)
    wr_rise && sel_ctrl && st_q.addr == ADDR_CMD_FOUR
    |=> st_q.cmd_four == $past(st_q.din_s2[7:0]))
    else $error("command register four not written");
  a_ctrl_step: assert property (@(posedge ref_clk)
    disable iff (reset)
    wr_rise && sel_ctrl |=> st_q.addr == $past(st_q.addr) + 11'h001)
    else $error("address did not step after control write");
  a_ro_noclear: assert property (@(posedge ref_clk)
    disable iff (reset)
    wr_rise && sel_ctrl && st_q.addr != ADDR_CMD_FOUR |=> !st_q.clear)
    else $error("write elsewhere cleared the signature");
  a_clear_pulse: assert property (@(posedge ref_clk)
    disable iff (reset)
    st_q.clear |=> !st_q.clear)
    else $error("analyzer clear longer than one cycle");
  // read data: one slice per address, held until the next read
  a_read_high: assert property (@(posedge ref_clk)
    disable iff (reset)
    rd_rise && sel_ctrl && st_q.bus10_s[1] && st_q.addr == ADDR_SIG_HIGH
    |=> mpu_d_out == $past(signature[30:21]))
    else $error("high slice read mismatch");
  a_read_low: assert property (@(posedge ref_clk)
    disable iff (reset)
    rd_rise && sel_ctrl && st_q.bus10_s[1] && st_q.addr == ADDR_SIG_LOW
    |=> mpu_d_out == $past(signature[10:1]))
    else $error("low slice read mismatch");
  a_read_extra: assert property (@(posedge ref_clk)
    disable iff (reset)
    rd_rise && sel_ctrl && st_q.bus10_s[1] && st_q.addr == ADDR_SIG_EXTRA
    |=> mpu_d_out == {7'h00, $past(signature[32]), $past(signature[31]),
      $past(signature[0])})
    else $error("extra bits read mismatch");
  a_byte_second: assert property (@(posedge ref_clk)
    disable iff (reset)
    rd_rise && sel_ctrl && !st_q.bus10_s[1] && st_q.byte_hi
    |=> !st_q.byte_hi && mpu_d_out[9:2] == 8'h00
      && st_q.addr == $past(st_q.addr) + 11'h001)
    else $error("8-bit second byte sequencing wrong");
  a_dout_holds: assert property (@(posedge ref_clk)
    disable iff (reset)
    !rd_rise |=> $stable(mpu_d_out))
    else $error("read data changed without a read");
endmodule

// ### verification/psa_host.sv
// host processor model driving the analyzer control port
`timescale 1ns/1ns
module psa_host (
  input wire logic ref_clk,
  input wire logic [9:0] mpu_d_out,
  output logic mpu_c1,
  output logic mpu_c0,
  output logic mpu_rd,
  output logic mpu_wr,
  output logic mpu_bus10,
  output logic [9:0] mpu_d_in
);
  initial begin
    {mpu_c1, mpu_c0, mpu_rd, mpu_wr, mpu_bus10} = 5'h01;
    mpu_d_in = 10'h000;
  end
  ////////////////////////////////////////////////////////////////////////
  // strobes held 5 cycles, gaps of at least 6: every port pin is resynced twice
  task automatic cyc(input logic c, input logic rd, input logic [9:0] d,
                     output logic [9:0] q);
    @(posedge ref_clk) #1;
    {mpu_c1, mpu_c0, mpu_d_in} = {c, 1'b0, d};
    @(posedge ref_clk) #1;
    if (rd) begin
      mpu_rd = 1'b1;
    end else begin
      mpu_wr = 1'b1;
    end
    repeat (5) @(posedge ref_clk);
    #1 q = mpu_d_out;
    {mpu_rd, mpu_wr} = 2'h0;
    repeat (4) @(posedge ref_clk);
    // released data lines show no stale value
    #1 mpu_d_in = ~d;
  endtask
  task automatic to_reg(input logic [10:0] a);
    logic [9:0] q;
    cyc(1'b0, 1'b0, {2'h0, a[7:0]}, q);
    cyc(1'b0, 1'b0, {7'h00, a[10:8]}, q);
  endtask
  task automatic put(input logic [10:0] a, input logic [7:0] v);
    logic [9:0] q;
    to_reg(a);
    cyc(1'b1, 1'b0, {2'h0, v}, q);
  endtask
  task automatic get(input logic [10:0] a, output logic [9:0] v);
    logic [9:0] lo;
    to_reg(a);
    cyc(1'b1, 1'b1, 10'h000, v);
    if (!mpu_bus10) begin
      cyc(1'b1, 1'b1, 10'h000, lo);
      v = {v[7:0], lo[1:0]};
    end
  endtask
endmodule

// ### verification/psa_top_test.sv
// self-checking bench for the pixel signature analyzer
`timescale 1ns/1ns
`define CHK(n, e, s) begin num_checks++; if ((s) !== (e)) begin \
  mismatches++; $display("wrong value %s exp %h got %h", n, e, s); end end
module psa_top_test;
  import psa_pkg::*;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic [29:0] pix = 30'h0;
  logic [29:0] p;
  logic act = 1'b0;
  logic c1, c0, rd, wr, b10, oe;
  logic [9:0] din, dout, v;
  logic [32:0] sig, exp_s;
  int mismatches = 0;
  int num_checks = 0;
  // rows: active, pixel, expected signature (feedback off)
  logic [63:0] rows [4] = '{{1'b1, 30'h3FFF_FFFF, 33'h0_3FFF_FFFF},
    {1'b0, 30'h0AAA_AAAA, 33'h0_3FFF_FFFF},
    {1'b1, 30'h1234_5678, 33'h0_1234_5678},
    {1'b0, 30'h0000_0001, 33'h0_1234_5678}};
  always #2 ref_clk = ~ref_clk;
  psa_top dut_u (.ref_clk(ref_clk), .reset(reset), .pixel_data(pix),
    .pixel_active(act), .mpu_c1(c1), .mpu_c0(c0), .mpu_rd(rd),
    .mpu_wr(wr), .mpu_bus10(b10), .mpu_d_in(din), .mpu_d_out(dout),
    .mpu_d_oe(oe), .signature(sig));
  psa_host host_u (.ref_clk(ref_clk), .mpu_d_out(dout), .mpu_c1(c1),
    .mpu_c0(c0), .mpu_rd(rd), .mpu_wr(wr), .mpu_bus10(b10),
    .mpu_d_in(din));
  ////////////////////////////////////////////////////////////////////////
  function automatic logic [32:0] nx(input logic [32:0] s,
                                     input logic [29:0] d);
    return {s[31:0], s[32] ^ s[19]} ^ {3'h0, d};
  endfunction
  task automatic step(input logic a, input logic [29:0] d, input int n);
    {act, pix} = {a, d};
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic summarize;
    if (mismatches == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge ref_clk);
    mismatches++;
    summarize();
  end
  initial begin
    repeat (10) @(posedge ref_clk);
    #1 reset = 1'b0;
    `CHK("sig", 33'h0, sig)
    `CHK("oe", 1'b0, oe)
    host_u.put(ADDR_CMD_FOUR, 8'h20);
    for (int i = 0; i < 4; i++) begin
      step(rows[i][63], rows[i][62:33], 2);
      `CHK("row", rows[i][32:0], sig)
    end
    host_u.put(ADDR_CMD_FOUR, 8'hA0);
    host_u.put(ADDR_CMD_FOUR, 8'hE0);
    `CHK("clear", 33'h0, sig)
    exp_s = 33'h0;
    for (int i = 1; i < 9; i++) begin
      p = 30'(i) * 30'h0765_4321;
      step(1'b1, p, 1);
      exp_s = nx(exp_s, p);
    end
    // blanking longer than the pipeline drain before the stop
    step(1'b0, 30'h3FFF_FFFF, 24);
    `CHK("frame", exp_s, sig)
    host_u.put(ADDR_CMD_FOUR, 8'hC0);
    step(1'b1, 30'h1234_5678, 4);
    `CHK("frozen", exp_s, sig)
    step(1'b0, 30'h0, 1);
    host_u.get(ADDR_SIG_HIGH, v);
    `CHK("high", exp_s[30:21], v)
    host_u.get(ADDR_SIG_MID, v);
    `CHK("mid", exp_s[20:11], v)
    host_u.get(ADDR_SIG_LOW, v);
    `CHK("low", exp_s[10:1], v)
    host_u.get(ADDR_SIG_EXTRA, v);
    `CHK("extra", {7'h00, exp_s[32:31], exp_s[0]}, v)
    host_u.put(ADDR_SIG_LOW, 8'h55);
    host_u.get(ADDR_SIG_LOW, v);
    `CHK("ro", exp_s[10:1], v)
    host_u.mpu_bus10 = 1'b0;
    host_u.get(ADDR_SIG_MID, v);
    `CHK("byte", exp_s[20:11], v)
    host_u.get(11'h014, v);
    `CHK("unmapped", 10'h000, v)
    host_u.to_reg(11'h0AB);
    host_u.cyc(1'b0, 1'b1, 10'h000, v);
    `CHK("addr", 10'h0AB, v)
    summarize();
  end
endmodule
